// file: core/ffc_pkg.sv
// Package for the frame filter control block: register map, fields, resets, access modes
package ffc_pkg;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [6:0] FFC_OFF_FILT_CFG  = 7'h00; // frame_filter_config
    localparam logic [6:0] FFC_OFF_TYPE_CFG  = 7'h01; // frame_type_filter_config
    localparam logic [6:0] FFC_OFF_SRC_CTRL  = 7'h02; // source_match_control
    localparam logic [6:0] FFC_OFF_STATUS    = 7'h03; // filter status and mode bits
    localparam logic [6:0] FFC_OFF_GAIN      = 7'h54; // gain_control_override

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] FFC_RST_FILT_CFG  = 8'h0d;
    localparam logic [7:0] FFC_RST_TYPE_CFG  = 8'h78;
    localparam logic [7:0] FFC_RST_SRC_CTRL  = 8'h07;
    localparam logic [7:0] FFC_RST_STATUS    = 8'h80;
    localparam logic [7:0] FFC_RST_GAIN      = 8'h00;

    // ---------------------------------------------------------------
    // Field positions in frame_filter_config
    // ---------------------------------------------------------------
    localparam int FFC_FILT_EN_BIT      = 0;
    localparam int FFC_COORD_BIT        = 1;
    localparam int FFC_MAXVER_LSB       = 2;
    localparam int FFC_RSVMASK_LSB      = 4;
    localparam int FFC_CFG_RSV_BIT      = 7;

    // Fields in frame_type_filter_config
    localparam int FFC_MODFT_LSB        = 1;
    localparam int FFC_ACCEPT_FT0_BIT   = 3;
    localparam int FFC_ACCEPT_RSV_BIT   = 7;

    // Fields in source_match_control
    localparam int FFC_SRC_EN_BIT       = 0;
    localparam int FFC_AUTOPEND_BIT     = 1;
    localparam int FFC_DATAREQ_BIT      = 2;

    // Fields in the status register
    localparam int FFC_ST_ACCEPT_BIT    = 0;
    localparam int FFC_ST_DROP_BIT      = 4;
    localparam int FFC_ST_SEEN_BIT      = 5;

    // Fields in gain_control_override
    localparam int FFC_GAIN_OVR_BIT     = 7;
    localparam int FFC_GAIN_W           = 6;

    // Fields of the received frame control field
    localparam int FFC_FCF_TYPE_LSB     = 0;
    localparam int FFC_FCF_RSV_LSB      = 7;
    localparam int FFC_FCF_DMODE_LSB    = 10;
    localparam int FFC_FCF_VER_LSB      = 12;

    // Frame types
    localparam logic [2:0] FFC_FT_DATA  = 3'h1;
    localparam logic [2:0] FFC_FT_CMD   = 3'h3;

    // ---------------------------------------------------------------
    // Bit access modes
    // ---------------------------------------------------------------
    localparam logic [2:0] FFC_M_RW     = 3'h0; // read and write
    localparam logic [2:0] FFC_M_R0     = 3'h1; // read_const_zero
    localparam logic [2:0] FFC_M_R1     = 3'h2; // read_const_one
    localparam logic [2:0] FFC_M_W1     = 3'h3; // write_one_only
    localparam logic [2:0] FFC_M_W0     = 3'h4; // write_zero_only
    localparam logic [2:0] FFC_M_RO     = 3'h5; // hardware owned, read only

    localparam logic [23:0] FFC_MODES_RW = {8{FFC_M_RW}};
    localparam logic [23:0] FFC_MODES_STATUS = {FFC_M_R1, FFC_M_R0, FFC_M_W0, FFC_M_W1,
                                                FFC_M_R0, FFC_M_R0, FFC_M_R0, FFC_M_RO};
    localparam logic [23:0] FFC_MODES_GAIN = {FFC_M_RW, FFC_M_R0, {6{FFC_M_RW}}};

endpackage : ffc_pkg

// file: core/ffc_reg_bit.sv
// One register bit with a selectable software access mode
`timescale 1ns/1ns
module ffc_reg_bit #(
    parameter logic [2:0] MODE = 3'h0,
    parameter logic       RST  = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic wr_i,      // Software write strobe for this register
    input  wire logic wdata_i,   // Written bit
    input  wire logic hw_set_i,  // Hardware event that sets the bit
    input  wire logic hw_clr_i,  // Hardware event that clears the bit
    output logic      q_o,       // Stored value, used by the logic
    output logic      rd_o       // Value returned on a read
);
    import ffc_pkg::*;

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    logic q;
    logic next_q;

    // Clear first, then software, then hardware set: a set from either
    // side is never lost to a clear landing in the same cycle
    always_comb begin
        next_q = hw_clr_i ? 1'b0 : q;
        case (MODE)
            FFC_M_RW: if (wr_i) next_q = wdata_i;
            FFC_M_W1: if (wr_i && wdata_i) next_q = 1'b1;
            FFC_M_W0: if (wr_i && !wdata_i) next_q = 1'b0;
            default:  ;
        endcase
        if (hw_set_i) next_q = 1'b1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= RST;
        end else begin
            q <= next_q;
        end
    end

    assign q_o = q;

    // Constant modes answer from the mode, not from storage
    always_comb begin
        case (MODE)
            FFC_M_R0: rd_o = 1'b0;
            FFC_M_R1: rd_o = 1'b1;
            default:  rd_o = q;
        endcase
    end

endmodule : ffc_reg_bit

// file: core/ffc_filter.sv
// Frame filter control: configuration registers and per-frame accept decision
//
// Notes on behaviour
// - Constant, write-one-only, write-zero-only bits honoured
// - Effective-value bits read what logic uses
// - Reserved mask AND frame bits rejects
// - Frame version above maximum is rejected
// - Coordinator accepts frames without destination
// - Enable bit turns on full filtering
// - Decision combines both configs and addresses
// - Filter off: all frames pass unfiltered
`timescale 1ns/1ns
module ffc_filter #(
    parameter int AW = 7
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    // Register port
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [7:0]    wdata_i,
    input  wire logic          wr_i,
    input  wire logic          rd_i,
    output logic      [7:0]    rdata_o,
    // Frame from the demodulator
    input  wire logic          fcf_valid_i,     // Frame control field present, one cycle
    input  wire logic [15:0]   fcf_i,
    input  wire logic          addr_match_i,    // Destination matches local address info
    input  wire logic          src_hit_i,       // Source found in an enabled pending entry
    input  wire logic          datareq_i,       // Frame is a data request command
    // Effective-value source
    input  wire logic [ffc_pkg::FFC_GAIN_W-1:0] auto_gain_i,
    // Results
    output logic               decision_o,      // One-cycle pulse, verdict valid
    output logic               accept_o,        // Frame goes to the receive buffer
    output logic               pend_o,          // Set pending bit in the acknowledgment
    output logic [ffc_pkg::FFC_GAIN_W-1:0] gain_eff_o
);
    import ffc_pkg::*;

    // ---------------------------------------------------------------
    // Register bits
    // ---------------------------------------------------------------
    logic [7:0] filt_cfg, filt_rd;
    logic [7:0] type_cfg, type_rd;
    logic [7:0] src_ctrl, src_rd;
    logic [7:0] status, status_rd;
    logic [7:0] gain, gain_rd;
    logic [7:0] st_set, st_clr;
    logic       wr_filt, wr_type, wr_src, wr_stat, wr_gain;

    assign wr_filt = wr_i && (addr_i == AW'(FFC_OFF_FILT_CFG));
    assign wr_type = wr_i && (addr_i == AW'(FFC_OFF_TYPE_CFG));
    assign wr_src  = wr_i && (addr_i == AW'(FFC_OFF_SRC_CTRL));
    assign wr_stat = wr_i && (addr_i == AW'(FFC_OFF_STATUS));
    assign wr_gain = wr_i && (addr_i == AW'(FFC_OFF_GAIN));

    for (genvar i = 0; i < 8; i++) begin : g_bits
        // bit seven stored plainly, host keeps it zero
        ffc_reg_bit #(.MODE(FFC_MODES_RW[3*i +: 3]), .RST(FFC_RST_FILT_CFG[i])) u_filt (
            .clk_i    (clk_i),
            .rst_n_i  (rst_n_i),
            .wr_i     (wr_filt),
            .wdata_i  (wdata_i[i]),
            .hw_set_i (1'b0),
            .hw_clr_i (1'b0),
            .q_o      (filt_cfg[i]),
            .rd_o     (filt_rd[i])
        );
        ffc_reg_bit #(.MODE(FFC_MODES_RW[3*i +: 3]), .RST(FFC_RST_TYPE_CFG[i])) u_type (
            .clk_i    (clk_i),
            .rst_n_i  (rst_n_i),
            .wr_i     (wr_type),
            .wdata_i  (wdata_i[i]),
            .hw_set_i (1'b0),
            .hw_clr_i (1'b0),
            .q_o      (type_cfg[i]),
            .rd_o     (type_rd[i])
        );
        ffc_reg_bit #(.MODE(FFC_MODES_RW[3*i +: 3]), .RST(FFC_RST_SRC_CTRL[i])) u_src (
            .clk_i    (clk_i),
            .rst_n_i  (rst_n_i),
            .wr_i     (wr_src),
            .wdata_i  (wdata_i[i]),
            .hw_set_i (1'b0),
            .hw_clr_i (1'b0),
            .q_o      (src_ctrl[i]),
            .rd_o     (src_rd[i])
        );
        ffc_reg_bit #(.MODE(FFC_MODES_STATUS[3*i +: 3]), .RST(FFC_RST_STATUS[i])) u_stat (
            .clk_i    (clk_i),
            .rst_n_i  (rst_n_i),
            .wr_i     (wr_stat),
            .wdata_i  (wdata_i[i]),
            .hw_set_i (st_set[i]),
            .hw_clr_i (st_clr[i]),
            .q_o      (status[i]),
            .rd_o     (status_rd[i])
        );
        ffc_reg_bit #(.MODE(FFC_MODES_GAIN[3*i +: 3]), .RST(FFC_RST_GAIN[i])) u_gain (
            .clk_i    (clk_i),
            .rst_n_i  (rst_n_i),
            .wr_i     (wr_gain),
            .wdata_i  (wdata_i[i]),
            .hw_set_i (1'b0),
            .hw_clr_i (1'b0),
            .q_o      (gain[i]),
            .rd_o     (gain_rd[i])
        );
    end

    // ---------------------------------------------------------------
    // Configuration fields
    // ---------------------------------------------------------------
    logic       filt_en, coord;
    logic [1:0] max_ver, mod_ft;
    logic [2:0] rsv_mask;

    assign filt_en  = filt_cfg[FFC_FILT_EN_BIT];
    assign coord    = filt_cfg[FFC_COORD_BIT];
    assign max_ver  = filt_cfg[FFC_MAXVER_LSB +: 2];
    assign rsv_mask = filt_cfg[FFC_RSVMASK_LSB +: 3];
    assign mod_ft   = type_cfg[FFC_MODFT_LSB +: 2];

    // ---------------------------------------------------------------
    // Frame evaluation
    // ---------------------------------------------------------------
    logic [2:0] ft;
    logic [1:0] dmode;
    logic       ft_ok, rsv_bad, ver_bad, dest_ok, drop_now;
    logic       next_accept, next_pend;

    // Frame type is altered for the check only, the stored frame is untouched
    always_comb begin
        ft = fcf_i[FFC_FCF_TYPE_LSB +: 3];
        case (mod_ft)
            2'h1:    ft[2] = ~ft[2];
            2'h2:    ft[2] = 1'b0;
            2'h3:    ft[2] = 1'b1;
            default: ft[2] = ft[2];
        endcase
    end

    // frame type acceptance from the second config
    assign ft_ok = ft[2] ? type_cfg[FFC_ACCEPT_RSV_BIT]
                         : type_cfg[FFC_ACCEPT_FT0_BIT + int'(ft[1:0])];
    assign rsv_bad = |(rsv_mask & fcf_i[FFC_FCF_RSV_LSB +: 3]);
    assign ver_bad = fcf_i[FFC_FCF_VER_LSB +: 2] > max_ver;

    // missing destination on data or command frames only acceptable at a coordinator
    assign dmode = fcf_i[FFC_FCF_DMODE_LSB +: 2];
    always_comb begin
        if (dmode != 2'h0) begin
            dest_ok = addr_match_i;
        end else if (ft == FFC_FT_DATA || ft == FFC_FT_CMD) begin
            dest_ok = coord;
        end else begin
            dest_ok = 1'b1;
        end
    end

    // Software may arm a one-shot drop of the next filtered frame
    assign drop_now = fcf_valid_i && filt_en && status[FFC_ST_DROP_BIT];

    // disabled filter passes everything, source bits ignored
    always_comb begin
        if (filt_en) begin
            next_accept = ft_ok && !rsv_bad && !ver_bad && dest_ok
                          && !status[FFC_ST_DROP_BIT];
            next_pend   = src_ctrl[FFC_SRC_EN_BIT] && src_ctrl[FFC_AUTOPEND_BIT]
                          && (!src_ctrl[FFC_DATAREQ_BIT] || datareq_i) && src_hit_i;
        end else begin
            next_accept = 1'b1;
            next_pend   = 1'b0;
        end
    end

    // one registered verdict per frame control field
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            decision_o <= 1'b0;
            accept_o   <= 1'b0;
            pend_o     <= 1'b0;
        end else begin
            decision_o <= fcf_valid_i;
            if (fcf_valid_i) begin
                accept_o <= next_accept;
                pend_o   <= next_pend && next_accept;
            end
        end
    end

    // Status: last verdict, sticky reject flag, one-shot drop consumed
    always_comb begin
        st_set = 8'h00;
        st_clr = 8'h00;
        st_set[FFC_ST_ACCEPT_BIT] = fcf_valid_i && next_accept;
        st_clr[FFC_ST_ACCEPT_BIT] = fcf_valid_i && !next_accept;
        st_set[FFC_ST_SEEN_BIT]   = fcf_valid_i && !next_accept;
        st_clr[FFC_ST_DROP_BIT]   = drop_now;
    end

    // ---------------------------------------------------------------
    // Effective gain value
    // ---------------------------------------------------------------
    logic [FFC_GAIN_W-1:0] next_gain_eff;

    // override picks the manual value, otherwise the generated one
    assign next_gain_eff = gain[FFC_GAIN_OVR_BIT] ? gain[FFC_GAIN_W-1:0] : auto_gain_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gain_eff_o <= '0;
        end else begin
            gain_eff_o <= next_gain_eff;
        end
    end

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    // Unmapped offsets read zero; read data stands one cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                AW'(FFC_OFF_FILT_CFG): rdata_o <= filt_rd;
                AW'(FFC_OFF_TYPE_CFG): rdata_o <= type_rd;
                AW'(FFC_OFF_SRC_CTRL): rdata_o <= src_rd;
                AW'(FFC_OFF_STATUS):   rdata_o <= status_rd;
                // effective value, not the stored manual field
                AW'(FFC_OFF_GAIN):     rdata_o <= {gain_rd[7:FFC_GAIN_W], next_gain_eff};
                default:               rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

endmodule : ffc_filter

// file: tb/ffc_filter_checker.sv
// Concurrent checks on the frame filter control ports
`timescale 1ns/1ns
module ffc_filter_checker
    import ffc_pkg::*;
#(
    parameter int AW = 7
) (
    input wire logic          clk_i,
    input wire logic          rst_n_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [7:0]    wdata_i,
    input wire logic          wr_i,
    input wire logic          rd_i,
    input wire logic [7:0]    rdata_o,
    input wire logic          fcf_valid_i,
    input wire logic [15:0]   fcf_i,
    input wire logic [5:0]    auto_gain_i,
    input wire logic          decision_o,
    input wire logic          accept_o,
    input wire logic          pend_o,
    input wire logic [5:0]    gain_eff_o
);
    // ---------------------------------------------------------------
    // Shadow registers
    // ---------------------------------------------------------------
    logic [7:0] cfg_sh;
    logic [7:0] gain_sh;
    logic [5:0] eff_gain;

    // Track software writes so checks know the active configuration
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_sh  <= FFC_RST_FILT_CFG;
            gain_sh <= FFC_RST_GAIN;
        end else if (wr_i) begin
            if (addr_i == FFC_OFF_FILT_CFG) begin
                cfg_sh <= wdata_i;
            end
            if (addr_i == FFC_OFF_GAIN) begin
                gain_sh <= wdata_i;
            end
        end
    end

    // Value the gain logic really uses
    assign eff_gain = gain_sh[7] ? gain_sh[5:0] : auto_gain_i;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    verdict_time_a: assert property (decision_o == $past(fcf_valid_i))
        else $error("verdict pulse not one cycle after frame");
    verdict_hold_a: assert property (!decision_o |-> $stable(accept_o) && $stable(pend_o))
        else $error("verdict changed without a frame");
    rsv_reject_a: assert property (fcf_valid_i && cfg_sh[0]
        && (cfg_sh[6:4] & fcf_i[9:7]) != 3'h0 |=> !accept_o)
        else $error("reserved bits frame accepted");
    version_reject_a: assert property (fcf_valid_i && cfg_sh[0]
        && fcf_i[13:12] > cfg_sh[3:2] |=> !accept_o)
        else $error("newer version frame accepted");
    filter_off_a: assert property (fcf_valid_i && !cfg_sh[0] |=> accept_o && !pend_o)
        else $error("unfiltered frame not passed");
    pend_accept_a: assert property (pend_o |-> accept_o)
        else $error("pending set on rejected frame");
    const_bits_a: assert property (rd_i && addr_i == FFC_OFF_STATUS
        |=> rdata_o[7:6] == 2'b10 && rdata_o[3:1] == 3'h0)
        else $error("constant status bits wrong");
    eff_read_a: assert property (rd_i && addr_i == FFC_OFF_GAIN
        |=> rdata_o[5:0] == $past(eff_gain) && !rdata_o[6])
        else $error("gain read not effective value");
    cfg_read_a: assert property (rd_i && addr_i == FFC_OFF_FILT_CFG
        |=> rdata_o == $past(cfg_sh))
        else $error("filter config read back wrong");
    gain_eff_a: assert property ($past(rst_n_i) |-> gain_eff_o == $past(eff_gain))
        else $error("effective gain output wrong");
endmodule : ffc_filter_checker

bind ffc_filter ffc_filter_checker #(.AW(AW)) u_ffc_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .fcf_valid_i(fcf_valid_i), .fcf_i(fcf_i),
    .auto_gain_i(auto_gain_i), .decision_o(decision_o), .accept_o(accept_o), .pend_o(pend_o),
    .gain_eff_o(gain_eff_o)
);

// file: tb/ffc_demod_model.sv
// Demodulator model handing frame control fields to the filter
`timescale 1ns/1ns
module ffc_demod_model (
    input  wire logic   clk_i,
    output logic        fcf_valid_o,
    output logic [15:0] fcf_o,
    output logic        addr_match_o,
    output logic        src_hit_o,
    output logic        datareq_o
);
    // Idle lines at time zero
    initial begin
        fcf_valid_o  = 1'b0;
        fcf_o        = 16'h0000;
        addr_match_o = 1'b0;
        src_hit_o    = 1'b0;
        datareq_o    = 1'b0;
    end

    task automatic send(input logic [15:0] f, input logic am, sh, dr);
        @(posedge clk_i);
        fcf_valid_o  <= 1'b1;
        fcf_o        <= f;
        addr_match_o <= am;
        src_hit_o    <= sh;
        datareq_o    <= dr;
        @(posedge clk_i);
        fcf_valid_o  <= 1'b0;
        // Inverted leftovers so stale fields never pass for a frame
        fcf_o        <= ~f;
        addr_match_o <= ~am;
        src_hit_o    <= ~sh;
        datareq_o    <= ~dr;
    endtask : send
endmodule : ffc_demod_model

// file: tb/ffc_filter_tb_top.sv
// Self-checking bench for the frame filter control block
`timescale 1ns/1ns
module ffc_filter_tb_top;
    import ffc_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_n_i, wr_i, rd_i, fcf_valid_i, addr_match_i, src_hit_i, datareq_i;
    logic        decision_o, accept_o, pend_o, rd_seen, rs, rq_, ra;
    logic [6:0]  addr_i;
    logic [7:0]  wdata_i, rdata_o, eb;
    logic [15:0] fcf_i;
    logic [5:0]  auto_gain_i, gain_eff_o;
    logic [2:0]  rr;
    logic [7:0]  rq[$];
    logic [1:0]  fq[$];
    int          error_cnt = 0, total_checks = 0, cyc = 0;

    always #5 clk_i = ~clk_i;

    ffc_filter #(.AW(7)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .fcf_valid_i(fcf_valid_i), .fcf_i(fcf_i), .addr_match_i(addr_match_i),
        .src_hit_i(src_hit_i), .datareq_i(datareq_i), .auto_gain_i(auto_gain_i),
        .decision_o(decision_o), .accept_o(accept_o), .pend_o(pend_o), .gain_eff_o(gain_eff_o));
    ffc_demod_model u_dm (.clk_i(clk_i), .fcf_valid_o(fcf_valid_i), .fcf_o(fcf_i),
        .addr_match_o(addr_match_i), .src_hit_o(src_hit_i), .datareq_o(datareq_i));

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [7:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        rq.push_back(e);
        @(posedge clk_i);
        rd_i   <= 1'b0;
    endtask : rd

    task automatic frame(input logic [15:0] f, input logic am, sh, dr, input logic [1:0] e);
        fq.push_back(e);
        u_dm.send(f, am, sh, dr);
    endtask : frame

    task automatic complete_run;
        // A note that never met its result is a mismatch too
        if (rq.size() != 0 || fq.size() != 0) begin
            error_cnt++;
            $display("unexpected at %0t: %0d results never appeared", $time,
                     rq.size() + fq.size());
        end
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    // Result watcher: oldest note is compared whenever a result shows
    always @(negedge clk_i) begin
        if (rd_seen === 1'b1) begin
            eb = (rq.size() > 0) ? rq.pop_front() : 8'hxx;
            chk(rdata_o, eb, "read data");
        end
        rd_seen = rd_i;
        if (decision_o === 1'b1) begin
            eb = (fq.size() > 0) ? {6'h00, fq.pop_front()} : 8'hxx;
            chk({6'h00, accept_o, pend_o}, eb, "verdict");
        end
    end

    // Hang guard well above the expected run length
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            complete_run();
        end
    end

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        rst_n_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = 7'h00; wdata_i = 8'h00;
        auto_gain_i = 6'h00; rd_seen = 1'b0;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        void'($urandom(34486));
        auto_gain_i <= 6'($urandom);
        rd(FFC_OFF_FILT_CFG, 8'h0d);
        rd(FFC_OFF_TYPE_CFG, 8'h78);
        rd(FFC_OFF_SRC_CTRL, 8'h07);
        rd(FFC_OFF_STATUS, 8'h80);
        rd(FFC_OFF_GAIN, {2'b00, auto_gain_i});
        wr(7'h10, 8'hff);
        rd(7'h10, 8'h00);
        $display("test reset_values done");
        // Write-one and write-zero bits ignore the other level
        wr(FFC_OFF_STATUS, 8'hff);
        rd(FFC_OFF_STATUS, 8'h90);
        wr(FFC_OFF_STATUS, 8'h00);
        rd(FFC_OFF_STATUS, 8'h90);
        frame(16'h0801, 1'b1, 1'b1, 1'b1, 2'b00);
        rd(FFC_OFF_STATUS, 8'ha0);
        wr(FFC_OFF_STATUS, 8'h00);
        rd(FFC_OFF_STATUS, 8'h80);
        frame(16'h0801, 1'b1, 1'b1, 1'b1, 2'b11);
        $display("test access_modes done");
        for (int m = 0; m < 8; m++) begin
            rr = 3'($urandom);
            rs = 1'($urandom);
            rq_ = 1'($urandom);
            ra = ((3'(m) & rr) == 3'h0);
            wr(FFC_OFF_FILT_CFG, 8'h0d | 8'(m << 4));
            frame(16'h0801 | (16'(rr) << 7), 1'b1, rs, rq_, {ra, ra & rs & rq_});
        end
        $display("test reserved_mask done");
        for (int v = 0; v < 16; v++) begin
            wr(FFC_OFF_FILT_CFG, 8'h01 | (8'(v[1:0]) << 2));
            frame(16'h0801 | (16'(v[3:2]) << 12), 1'b1, 1'b0, 1'b0, {v[3:2] <= v[1:0], 1'b0});
        end
        $display("test frame_version done");
        for (int c = 0; c < 2; c++) begin
            wr(FFC_OFF_FILT_CFG, 8'h01 | 8'(c << 1));
            frame(16'h0001, 1'b0, 1'b0, 1'b0, {c[0], 1'b0});
            frame(16'h0801, 1'b0, 1'b0, 1'b0, 2'b00);
        end
        wr(FFC_OFF_TYPE_CFG, 8'h68);
        frame(16'h0801, 1'b1, 1'b0, 1'b0, 2'b00);
        // Forcing the type msb turns a data frame into a refused reserved type
        wr(FFC_OFF_TYPE_CFG, 8'h7e);
        frame(16'h0801, 1'b1, 1'b0, 1'b0, 2'b00);
        wr(FFC_OFF_TYPE_CFG, 8'h78);
        $display("test coordinator done");
        wr(FFC_OFF_FILT_CFG, 8'h70);
        rd(FFC_OFF_FILT_CFG, 8'h70);
        frame(16'h3b81, 1'b0, 1'b1, 1'b1, 2'b10);
        wr(FFC_OFF_FILT_CFG, 8'h0d);
        $display("test filter_off done");
        wr(FFC_OFF_GAIN, 8'hff);
        rd(FFC_OFF_GAIN, 8'hbf);
        wr(FFC_OFF_GAIN, 8'h95);
        rd(FFC_OFF_GAIN, 8'h95);
        // Output sampled away from the edge that launches it
        @(negedge clk_i);
        chk({2'b00, gain_eff_o}, 8'h15, "effective gain");
        @(posedge clk_i);
        auto_gain_i <= 6'($urandom);
        wr(FFC_OFF_GAIN, 8'h15);
        rd(FFC_OFF_GAIN, {2'b00, auto_gain_i});
        $display("test effective_gain done");
        repeat (4) @(posedge clk_i);
        complete_run();
    end
endmodule : ffc_filter_tb_top
